// ===== hdl/link_cfg_pkg.sv
`default_nettype none
package link_cfg_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int BANK_DEPTH = 32;

	// Register offsets
	localparam logic [7:0] OFS_OWN_ADDR = 8'h00;
	localparam logic [7:0] OFS_PEER_ADDR = 8'h01;
	localparam logic [7:0] OFS_SPREAD_AUDIO = 8'h02;
	localparam logic [7:0] OFS_SPREAD_CAL = 8'h03;
	localparam logic [7:0] OFS_LINK_EN = 8'h04;
	localparam logic [7:0] OFS_BANK_LAST = 8'h1F;

	// Reset values and unmapped read value
	localparam logic [7:0] RST_OWN_ADDR = 8'h80;
	localparam logic [7:0] RST_PEER_ADDR = 8'h90;
	localparam logic [7:0] RST_SPREAD_AUDIO = 8'h1F;
	localparam logic [7:0] RST_SPREAD_CAL = 8'h00;
	localparam logic [7:0] RST_LINK_EN = 8'h07;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// Field positions
	localparam int POS_CONFIG_LOCK = 0;
	localparam int POS_SS_LSB = 5;
	localparam int POS_LINK_TX = 7;
	localparam int POS_SLEEP = 4;
	localparam int POS_PEER_RSVD = 0;

	// Interface type codes
	localparam logic [1:0] IF_TYPE_UART = 2'h1;

	// Bus width modes
	localparam logic [1:0] BW_24 = 2'h0;
	localparam logic [1:0] BW_32 = 2'h1;
	localparam logic [1:0] BW_HIGH = 2'h2;

	// Rate and audio format limits
	localparam logic [7:0] PCLK_MAX_WIDE_MHZ = 8'h68;
	localparam logic [7:0] PCLK_MAX_32_MHZ = 8'h4E;
	localparam logic [11:0] LINE_RATE_MAX_MBPS = 12'hC30;
	localparam logic [7:0] AUDIO_RATE_MIN_KHZ = 8'h20;
	localparam logic [7:0] AUDIO_RATE_MAX_KHZ = 8'hC0;
	localparam logic [5:0] AUDIO_DEPTH_MIN = 6'h08;
	localparam logic [5:0] AUDIO_DEPTH_MAX = 6'h20;
	localparam logic [3:0] AUDIO_CHAN_MAX = 4'h8;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} acc_s;

	typedef struct packed {
		logic [6:0] own_addr_field;
		logic config_lock;
		logic [6:0] peer_addr_field;
		logic [2:0] spread_setting;
		logic audio_chan_enable;
		logic [1:0] pixel_clock_range;
		logic [1:0] serial_rate_range;
		logic [1:0] mod_rate_cal_mode;
		logic [5:0] sawtooth_divider;
		logic link_tx_enable;
		logic cfg_link_enable;
		logic test_pattern_enable;
		logic sleep;
		logic [1:0] local_cc_if_type;
		logic reverse_cc_enable;
		logic forward_cc_enable;
	} cfg_s;

endpackage : link_cfg_pkg
`default_nettype wire

// ===== hdl/cfg_word_bank.sv
`default_nettype none
module cfg_word_bank #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] words_r [DEPTH];

	// Word store with registered read port
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_data <= '0;
			for (int i = 0; i < DEPTH; i++)
			begin
				words_r[i] <= '0;
			end
		end
		else
		begin
			rd_data <= words_r[rd_addr];
			if (wr_en)
			begin
				words_r[wr_addr] <= wr_data;
			end
		end
	end
endmodule : cfg_word_bank
`default_nettype wire

// ===== hdl/link_serializer_config_regs.sv
`default_nettype none
module link_serializer_config_regs (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic cc_base_mode,
	input wire link_cfg_pkg::acc_s acc,
	output logic acc_ready,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic [3:0] strap_config_pins,
	input wire logic cc_direction_pin,
	input wire logic iic_select_pin,
	input wire logic mode_select_pin,
	input wire logic [1:0] bus_width_mode,
	input wire logic [11:0] line_rate_mbps,
	input wire logic [7:0] audio_rate_khz,
	input wire logic [5:0] audio_depth,
	input wire logic [3:0] audio_channels,
	output link_cfg_pkg::cfg_s cfg,
	output logic [7:0] pclk_max_mhz,
	output logic line_rate_ok,
	output logic audio_fmt_ok,
	output logic cc_full_duplex,
	output logic cc_passthrough
);
	import link_cfg_pkg::*;

	typedef struct packed {
		cfg_s cfg;
		logic strap_done;
		logic rd_pending;
		logic rd_low;
		logic [7:0] rd_low_data;
	} state_s;

	state_s st_r;
	state_s st_nxt;
	logic [7:0] bank_q;
	logic take;
	logic do_write;
	logic in_bank;

	function automatic logic [7:0] low_reg_read(input cfg_s c, input logic [7:0] a);
		logic [7:0] v;
		v = RD_UNMAPPED;
		unique case (a)
			OFS_OWN_ADDR: v = {c.own_addr_field, c.config_lock};
			OFS_PEER_ADDR: v = {c.peer_addr_field, 1'b0};
			OFS_SPREAD_AUDIO: v = {c.spread_setting, c.audio_chan_enable, c.pixel_clock_range,
				c.serial_rate_range};
			OFS_SPREAD_CAL: v = {c.mod_rate_cal_mode, c.sawtooth_divider};
			OFS_LINK_EN: v = {c.link_tx_enable, c.cfg_link_enable, c.test_pattern_enable, c.sleep,
				c.local_cc_if_type, c.reverse_cc_enable, c.forward_cc_enable};
			default: v = RD_UNMAPPED;
		endcase
		return v;
	endfunction : low_reg_read

	// Access gating
	assign acc_ready = st_r.strap_done && cc_base_mode;
	assign take = acc.valid && acc_ready;
	assign in_bank = acc.addr <= OFS_BANK_LAST;
	assign do_write = take && acc.write && in_bank && !st_r.cfg.config_lock;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rd_pending = 1'b0;
		// Strap capture on first edge after reset release
		if (!st_r.strap_done)
		begin
			st_nxt.strap_done = 1'b1;
			st_nxt.cfg.spread_setting[0] = strap_config_pins[0];
			st_nxt.cfg.link_tx_enable = strap_config_pins[2];
			st_nxt.cfg.sleep = strap_config_pins[3] & cc_direction_pin;
		end
		if (take && !acc.write)
		begin
			st_nxt.rd_pending = 1'b1;
			st_nxt.rd_low = acc.addr <= OFS_LINK_EN || !in_bank;
			st_nxt.rd_low_data = low_reg_read(st_r.cfg, acc.addr);
		end
		// Locked bank still lets the lock bit itself be cleared
		if (take && acc.write && acc.addr == OFS_OWN_ADDR && st_r.cfg.config_lock)
		begin
			st_nxt.cfg.config_lock = acc.wdata[POS_CONFIG_LOCK];
		end
		if (do_write)
		begin
			unique case (acc.addr)
				OFS_OWN_ADDR:
				begin
					{st_nxt.cfg.own_addr_field, st_nxt.cfg.config_lock} = acc.wdata;
				end
				OFS_PEER_ADDR:
				begin
					st_nxt.cfg.peer_addr_field = acc.wdata[7:1];
				end
				OFS_SPREAD_AUDIO:
				begin
					{st_nxt.cfg.spread_setting, st_nxt.cfg.audio_chan_enable, st_nxt.cfg.pixel_clock_range,
						st_nxt.cfg.serial_rate_range} = acc.wdata;
				end
				OFS_SPREAD_CAL:
				begin
					{st_nxt.cfg.mod_rate_cal_mode, st_nxt.cfg.sawtooth_divider} = acc.wdata;
				end
				OFS_LINK_EN:
				begin
					{st_nxt.cfg.link_tx_enable, st_nxt.cfg.cfg_link_enable, st_nxt.cfg.test_pattern_enable,
						st_nxt.cfg.sleep, st_nxt.cfg.local_cc_if_type, st_nxt.cfg.reverse_cc_enable,
						st_nxt.cfg.forward_cc_enable} = acc.wdata;
				end
				default:
				begin
					st_nxt.cfg = st_nxt.cfg;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_r.cfg.own_addr_field <= RST_OWN_ADDR[7:1];
			st_r.cfg.config_lock <= RST_OWN_ADDR[0];
			st_r.cfg.peer_addr_field <= RST_PEER_ADDR[7:1];
			st_r.cfg.spread_setting <= RST_SPREAD_AUDIO[7:5];
			st_r.cfg.audio_chan_enable <= RST_SPREAD_AUDIO[4];
			st_r.cfg.pixel_clock_range <= RST_SPREAD_AUDIO[3:2];
			st_r.cfg.serial_rate_range <= RST_SPREAD_AUDIO[1:0];
			st_r.cfg.mod_rate_cal_mode <= RST_SPREAD_CAL[7:6];
			st_r.cfg.sawtooth_divider <= RST_SPREAD_CAL[5:0];
			st_r.cfg.link_tx_enable <= RST_LINK_EN[7];
			st_r.cfg.cfg_link_enable <= RST_LINK_EN[6];
			st_r.cfg.test_pattern_enable <= RST_LINK_EN[5];
			st_r.cfg.sleep <= RST_LINK_EN[4];
			st_r.cfg.local_cc_if_type <= RST_LINK_EN[3:2];
			st_r.cfg.reverse_cc_enable <= RST_LINK_EN[1];
			st_r.cfg.forward_cc_enable <= RST_LINK_EN[0];
			st_r.strap_done <= 1'b0;
			st_r.rd_pending <= 1'b0;
			st_r.rd_low <= 1'b0;
			st_r.rd_low_data <= 8'h00;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Remaining words of the bank
	cfg_word_bank #(
		.WIDTH(DATA_W),
		.DEPTH(BANK_DEPTH)
	) u_bank (
		.clk(clk),
		.arst_n(arst_n),
		.wr_en(do_write && acc.addr > OFS_LINK_EN),
		.wr_addr(acc.addr[4:0]),
		.wr_data(acc.wdata),
		.rd_addr(acc.addr[4:0]),
		.rd_data(bank_q)
	);

	// Read return, one cycle after the request
	assign rd_valid = st_r.rd_pending;
	assign rd_data = !st_r.rd_pending ? 8'h00 : (st_r.rd_low ? st_r.rd_low_data : bank_q);

	assign cfg = st_r.cfg;

	// Derived operating limits
	assign pclk_max_mhz = (bus_width_mode == BW_32) ? PCLK_MAX_32_MHZ : PCLK_MAX_WIDE_MHZ;
	assign line_rate_ok = line_rate_mbps <= LINE_RATE_MAX_MBPS;
	assign audio_fmt_ok = audio_rate_khz >= AUDIO_RATE_MIN_KHZ && audio_rate_khz <= AUDIO_RATE_MAX_KHZ
		&& audio_depth >= AUDIO_DEPTH_MIN && audio_depth <= AUDIO_DEPTH_MAX
		&& audio_channels != 4'h0 && audio_channels <= AUDIO_CHAN_MAX;
	assign cc_full_duplex = st_r.cfg.local_cc_if_type == IF_TYPE_UART;
	assign cc_passthrough = !cc_base_mode;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	logic past_valid_r;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			past_valid_r <= 1'b0;
		end
		else
		begin
			past_valid_r <= 1'b1;
		end
	end

	bypass_no_read_a: assert property (acc.valid && !cc_base_mode |=> !rd_valid)
		else $error("read answered outside base mode");
	read_one_cycle_a: assert property (take && !acc.write |=> rd_valid)
		else $error("read not answered next cycle");
	own_addr_readback_a: assert property (take && !acc.write && acc.addr == OFS_OWN_ADDR
		|=> rd_data == {$past(cfg.own_addr_field), $past(cfg.config_lock)})
		else $error("own address readback wrong");
	strap_tx_a: assert property (!past_valid_r ##1 past_valid_r
		|-> cfg.link_tx_enable == $past(strap_config_pins[2]))
		else $error("transmit enable strap not captured");
	locked_hold_a: assert property (cfg.config_lock && take && acc.addr == OFS_PEER_ADDR
		|=> $stable(cfg.peer_addr_field))
		else $error("write took effect while locked");
	unlocked_write_a: assert property (!cfg.config_lock && take && acc.write && acc.addr == OFS_SPREAD_CAL
		|=> {cfg.mod_rate_cal_mode, cfg.sawtooth_divider} == $past(acc.wdata))
		else $error("unlocked write lost");
	peer_rsvd_a: assert property (rd_valid && $past(acc.addr) == OFS_PEER_ADDR && $past(take)
		|-> rd_data[POS_PEER_RSVD] == 1'b0)
		else $error("peer reserved bit not zero");
	pclk_limit_a: assert property (bus_width_mode == BW_32 |-> pclk_max_mhz == PCLK_MAX_32_MHZ)
		else $error("32-bit pixel clock limit wrong");
	duplex_a: assert property (cfg.local_cc_if_type != IF_TYPE_UART |-> !cc_full_duplex)
		else $error("I2C traffic shown as full duplex");

	// Operating limits
	duplex_uart_a: assert property (cfg.local_cc_if_type == IF_TYPE_UART |-> cc_full_duplex)
		else $error("UART traffic not shown as full duplex");
	pclk_wide_a: assert property (bus_width_mode != BW_32 |-> pclk_max_mhz == PCLK_MAX_WIDE_MHZ)
		else $error("wide pixel clock limit wrong");
	passthrough_a: assert property (!cc_base_mode |-> cc_passthrough && !acc_ready)
		else $error("bypass mode still offers register access");
	line_limit_a: assert property (line_rate_mbps > LINE_RATE_MAX_MBPS |-> !line_rate_ok)
		else $error("line rate above limit accepted");
	line_ok_a: assert property (line_rate_mbps <= LINE_RATE_MAX_MBPS |-> line_rate_ok)
		else $error("line rate within limit refused");
	audio_depth_a: assert property (audio_depth < AUDIO_DEPTH_MIN || audio_depth > AUDIO_DEPTH_MAX
		|-> !audio_fmt_ok)
		else $error("audio depth out of range accepted");
	audio_rate_a: assert property (audio_rate_khz < AUDIO_RATE_MIN_KHZ
		|| audio_rate_khz > AUDIO_RATE_MAX_KHZ |-> !audio_fmt_ok)
		else $error("audio rate out of range accepted");
	audio_chan_a: assert property (audio_channels == 4'h0 || audio_channels > AUDIO_CHAN_MAX
		|-> !audio_fmt_ok)
		else $error("audio channel count out of range accepted");

	// Power-up values seen at the first cycles after reset
	no_early_ready_a: assert property (!past_valid_r |-> !acc_ready)
		else $error("access offered before strap capture");
	ready_after_strap_a: assert property (!past_valid_r ##1 past_valid_r |-> acc_ready == cc_base_mode)
		else $error("access not offered after strap capture");
	own_reset_a: assert property (!past_valid_r ##1 past_valid_r
		|-> {cfg.own_addr_field, cfg.config_lock} == RST_OWN_ADDR)
		else $error("own address power-up value wrong");
	peer_reset_a: assert property (!past_valid_r ##1 past_valid_r
		|-> cfg.peer_addr_field == RST_PEER_ADDR[7:1])
		else $error("peer address power-up value wrong");
	audio_reset_a: assert property (!past_valid_r ##1 past_valid_r
		|-> cfg.audio_chan_enable == RST_SPREAD_AUDIO[4] && cfg.spread_setting[2:1] == RST_SPREAD_AUDIO[7:6])
		else $error("audio enable or spread power-up value wrong");
	strap_ss_a: assert property (!past_valid_r ##1 past_valid_r
		|-> cfg.spread_setting[0] == $past(strap_config_pins[0]))
		else $error("spread strap not captured");
	range_reset_a: assert property (!past_valid_r ##1 past_valid_r
		|-> cfg.pixel_clock_range == RST_SPREAD_AUDIO[3:2] && cfg.serial_rate_range == RST_SPREAD_AUDIO[1:0])
		else $error("range detection power-up value wrong");
	cal_reset_a: assert property (!past_valid_r ##1 past_valid_r
		|-> {cfg.mod_rate_cal_mode, cfg.sawtooth_divider} == RST_SPREAD_CAL)
		else $error("spread calibration power-up value wrong");
	strap_sleep_a: assert property (!past_valid_r ##1 past_valid_r
		|-> cfg.sleep == $past(strap_config_pins[3] & cc_direction_pin))
		else $error("sleep strap not captured");
	test_off_a: assert property (!past_valid_r ##1 past_valid_r
		|-> !cfg.cfg_link_enable && !cfg.test_pattern_enable)
		else $error("configuration link or test pattern enabled at power-up");
	if_type_reset_a: assert property (!past_valid_r ##1 past_valid_r
		|-> cfg.local_cc_if_type == RST_LINK_EN[3:2])
		else $error("interface type power-up value wrong");
	cc_en_reset_a: assert property (!past_valid_r ##1 past_valid_r
		|-> cfg.reverse_cc_enable && cfg.forward_cc_enable)
		else $error("control channel enables off at power-up");

	// Access effects
	bypass_no_write_a: assert property (acc.valid && acc.write && !cc_base_mode && st_r.strap_done
		|=> $stable(cfg))
		else $error("write took effect outside base mode");
	peer_readback_a: assert property (take && !acc.write && acc.addr == OFS_PEER_ADDR
		|=> rd_data == {$past(cfg.peer_addr_field), 1'b0})
		else $error("peer address readback wrong");
	unmapped_read_a: assert property (take && !acc.write && acc.addr > OFS_BANK_LAST
		|=> rd_data == RD_UNMAPPED)
		else $error("read beyond the bank not zero");
	read_no_change_a: assert property (take && !acc.write |=> $stable(cfg))
		else $error("read altered configuration");
	own_write_a: assert property (!cfg.config_lock && take && acc.write && acc.addr == OFS_OWN_ADDR
		|=> {cfg.own_addr_field, cfg.config_lock} == $past(acc.wdata))
		else $error("own address write lost");
	peer_write_a: assert property (!cfg.config_lock && take && acc.write && acc.addr == OFS_PEER_ADDR
		|=> cfg.peer_addr_field == $past(acc.wdata[7:1]))
		else $error("peer address write lost");
	spread_write_a: assert property (!cfg.config_lock && take && acc.write && acc.addr == OFS_SPREAD_AUDIO
		|=> {cfg.spread_setting, cfg.audio_chan_enable, cfg.pixel_clock_range, cfg.serial_rate_range}
			== $past(acc.wdata))
		else $error("spread and audio write lost");
	link_write_a: assert property (!cfg.config_lock && take && acc.write && acc.addr == OFS_LINK_EN
		|=> {cfg.link_tx_enable, cfg.cfg_link_enable, cfg.test_pattern_enable, cfg.sleep, cfg.local_cc_if_type,
			cfg.reverse_cc_enable, cfg.forward_cc_enable} == $past(acc.wdata))
		else $error("link enable write lost");
	locked_write_a: assert property (cfg.config_lock && take && acc.write && acc.addr != OFS_OWN_ADDR
		|=> $stable(cfg))
		else $error("locked register changed");
	lock_clear_a: assert property (cfg.config_lock && take && acc.write && acc.addr == OFS_OWN_ADDR
		|=> $stable(cfg.own_addr_field) && cfg.config_lock == $past(acc.wdata[POS_CONFIG_LOCK]))
		else $error("locked own address write not limited to lock bit");
	rd_cause_a: assert property (rd_valid |-> $past(take) && !$past(acc.write))
		else $error("read answer without request");
	rd_pulse_a: assert property (rd_valid && !(take && !acc.write) |=> !rd_valid)
		else $error("read answer longer than one cycle");
	rd_idle_a: assert property (!rd_valid |-> rd_data == 8'h00)
		else $error("read data not zero while idle");

	cover_read_c: cover property (take && !acc.write ##1 rd_valid);
	cover_lock_c: cover property (take && acc.write && acc.addr == OFS_OWN_ADDR && acc.wdata[0]);
	cover_unlock_c: cover property (cfg.config_lock ##1 !cfg.config_lock);
	cover_bank_c: cover property (do_write && acc.addr == OFS_BANK_LAST);
	cover_bypass_c: cover property (acc.valid && !acc.write && !cc_base_mode);
endmodule : link_serializer_config_regs
`default_nettype wire

// ===== testbench/cc_master.sv
`default_nettype none
module cc_master (
	input wire logic clk,
	output var link_cfg_pkg::acc_s acc,
	input wire logic acc_ready,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	import link_cfg_pkg::*;
	logic [7:0] peer_mirror [0:1];
	initial acc = '0;
	// One request, held until ready, answer sampled a cycle on
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [8:0] r);
		int n;
		n = 0;
		@(posedge clk);
		acc <= '{valid: 1'b1, write: w, addr: a, wdata: d};
		@(negedge clk);
		while (acc_ready !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		acc <= '0;
		if (w && a < 8'h02)
			peer_mirror[a[0]] = d;
		@(negedge clk);
		r = {rd_valid, rd_data};
	endtask : xfer
	// Strobe without waiting for ready
	task automatic poke(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		acc <= '{valid: 1'b1, write: w, addr: a, wdata: d};
		@(posedge clk);
		acc <= '0;
	endtask : poke
endmodule : cc_master
`default_nettype wire

// ===== testbench/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import link_cfg_pkg::*;
	logic clk, arst_n, cc_base_mode, acc_ready, rd_valid, cc_direction_pin, iic_select_pin, mode_select_pin;
	logic line_rate_ok, audio_fmt_ok, cc_full_duplex, cc_passthrough;
	logic [7:0] rd_data, pclk_max_mhz, audio_rate_khz, d;
	logic [3:0] strap_config_pins, audio_channels;
	logic [1:0] bus_width_mode;
	logic [11:0] line_rate_mbps;
	logic [5:0] audio_depth;
	logic [8:0] r;
	logic [31:0] rnd;
	acc_s acc;
	cfg_s cfg;
	integer seed;
	int mreg [0:31];
	int n_errors, cmp_count, cyc, k, a, i;
	link_serializer_config_regs DUT (.clk, .arst_n, .cc_base_mode, .acc, .acc_ready, .rd_data, .rd_valid,
		.strap_config_pins, .cc_direction_pin, .iic_select_pin, .mode_select_pin, .bus_width_mode,
		.line_rate_mbps, .audio_rate_khz, .audio_depth, .audio_channels, .cfg, .pclk_max_mhz,
		.line_rate_ok, .audio_fmt_ok, .cc_full_duplex, .cc_passthrough);
	cc_master mcu (.clk, .acc, .acc_ready, .rd_valid, .rd_data);
	always #12.5 clk = ~clk;
	task automatic test_done();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_errors++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Reference bank behaviour
	function automatic void mwr(int wa, int wd);
		if (wa > 31 || (mreg[0] % 2 == 1 && wa != 0))
			return;
		if (mreg[0] % 2 == 1)
			mreg[0] = mreg[0] - 1 + wd % 2;
		else
			mreg[wa] = (wa == 1) ? wd / 2 * 2 : wd;
	endfunction : mwr
	task automatic rdchk(input int ra);
		mcu.xfer(1'b0, 8'(ra), 8'h00, r);
		chk("read", r, {1'b1, ra > 31 ? 8'h00 : 8'(mreg[ra])});
	endtask : rdchk
	task automatic wrm(input int wa, input logic [7:0] wd);
		mcu.xfer(1'b1, 8'(wa), wd, r);
		mwr(wa, int'(wd));
		chk("write", r, 0);
	endtask : wrm
	task automatic cfgchk();
		chk("cfg", cfg, {mreg[0][7:0], mreg[1][7:1], mreg[2][7:0], mreg[3][7:0], mreg[4][7:0]});
	endtask : cfgchk
	task automatic side();
		logic ok;
		ok = audio_rate_khz inside {[8'h20:8'hC0]} && audio_depth inside {[6'h08:6'h20]};
		ok = ok && audio_channels inside {[4'h1:4'h8]};
		chk("pclk", pclk_max_mhz, bus_width_mode == 2'h1 ? 8'h4E : 8'h68);
		chk("line", line_rate_ok, line_rate_mbps <= 12'hC30);
		chk("audio", audio_fmt_ok, ok);
		chk("duplex", cc_full_duplex, mreg[4][3:2] == 1);
		chk("bypass", cc_passthrough, !cc_base_mode);
	endtask : side
	task automatic do_reset(input int rk);
		rnd = $random(seed);
		@(posedge clk);
		arst_n <= 1'b0;
		strap_config_pins <= {rk[1:0], rnd[1:0]};
		cc_direction_pin <= rk[1] | rnd[2];
		iic_select_pin <= rnd[3];
		mode_select_pin <= rnd[4];
		mreg = '{default: 0};
		mreg[0] = 8'h80;
		mreg[1] = 8'h90;
		mreg[2] = rnd[0] ? 8'h3F : 8'h1F;
		mreg[4] = 8'h07 + rk[0] * 8'h80 + rk[1] * 8'h10;
		repeat (10) @(posedge clk);
		chk("ready", acc_ready, 0);
		arst_n <= 1'b1;
	endtask : do_reset
	initial
	begin
		seed = 32'h901D9C92;
		clk = 1'b0;
		arst_n = 1'b0;
		cc_base_mode = 1'b1;
		{strap_config_pins, cc_direction_pin, iic_select_pin, mode_select_pin} = '0;
		{bus_width_mode, line_rate_mbps, audio_rate_khz, audio_depth, audio_channels} = '0;
		// Power-up values for every combination of strap pins 3 and 2, pin 0 random
		for (k = 0; k < 4; k++)
		begin
			do_reset(k);
			for (a = 0; a < 5; a++)
				rdchk(a);
			cfgchk();
		end
		// Random traffic, unmapped offsets included
		for (i = 0; i < 200; i++)
		begin
			rnd = $random(seed);
			a = rnd[8] ? rnd[7:0] : rnd[4:0];
			d = rnd[19:12];
			if (a == 0)
				d[0] = 1'b0;
			@(posedge clk);
			bus_width_mode <= 2'(rnd[21:20] % 3);
			line_rate_mbps <= 12'hC20 + 12'(rnd[26:22]);
			rnd = $random(seed);
			audio_rate_khz <= rnd[7:0];
			audio_depth <= rnd[13:8];
			audio_channels <= rnd[17:14];
			if (rnd[31])
				wrm(a, d);
			else
				rdchk(a);
			side();
			cfgchk();
		end
		// Receiver copy of the peer address follows the written value
		wrm(1, 8'h66);
		chk("mirror", cfg.peer_addr_field, mcu.peer_mirror[1][7:1]);
		// Lock, ignored write, lock-only clear
		wrm(0, 8'hA5);
		wrm(2, 8'h00);
		rdchk(2);
		wrm(0, 8'h00);
		rdchk(0);
		wrm(2, 8'h00);
		rdchk(2);
		// Bypass refuses access
		@(posedge clk);
		cc_base_mode <= 1'b0;
		@(negedge clk);
		chk("ready", acc_ready, 0);
		side();
		mcu.poke(1'b1, 8'h03, 8'hFF);
		mcu.poke(1'b0, 8'h03, 8'h00);
		@(negedge clk);
		chk("rdv", rd_valid, 0);
		cfgchk();
		@(posedge clk);
		cc_base_mode <= 1'b1;
		rdchk(3);
		test_done();
	end
endmodule : tb
`default_nettype wire
